// *** logic/radio_power_mode_sequencer.sv ***
// Operation
// - Regulators follow written mode automatically
// - Readable regulator ready flag
// - Readable brown-out flag below threshold
// - Power-down: supplies off, FIFO refused, flushed
// - Deep-sleep: all off, registers lost (only the interrupt mask is reset; mode and event bits kept)
// - Four-bit mode codes fixed
// - Power-down waits for empty FIFO
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module radio_power_mode_sequencer
  import radio_pwr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        i_fifo_empty,   // FIFO drained (same clock)
  input  wire logic        i_brownout_pin, // comparator output, async
  output logic             o_core_supply_on,
  output logic             o_xtal_ref_on,
  output logic             o_rx_on,
  output logic             o_tx_on,
  output logic             o_fifo_access_ok,
  output logic             o_fifo_flush,
  output logic             o_regs_lost,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_SETTLE} seq_e;

  typedef struct packed {
    seq_e       seq;
    logic [3:0] mode_req;   // Last legal code written; undefined codes leave it unchanged
    logic [3:0] mode_act;   // Code in force
    logic [15:0] cnt;       // Regulator settle count
    logic       ready;
    logic [1:0] bo_sync;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic       dp_valid;   // AHB data phase pending
    logic       dp_write;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic       flush;
  } state_s;

  state_s q, next_q;  // Registered state and its next value

  // Whether a code is one of the defined modes
  function automatic logic mode_legal(input logic [3:0] m);
    mode_legal = (m == MODE_OFF) || (m == MODE_DEEP) || (m == MODE_STANDBY) ||
                 (m == MODE_FIFO) || (m == MODE_RX) || (m == MODE_TX);
  endfunction : mode_legal

  logic take;
  logic bo;
  logic [2:0] ev;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q         = q;
    take           = hsel && hready && htrans[1];
    bo             = q.bo_sync[1];
    next_q.bo_sync = {q.bo_sync[0], i_brownout_pin};
    next_q.flush   = 1'b0;
    ev             = 3'h0;
    // Register writes land in the data phase
    if (q.dp_valid && q.dp_write) begin
      case (q.dp_addr)
        OFS_MODE: begin
          // Undefined codes ignored, so regulators never see an odd mode
          if (mode_legal(hwdata[3:0])) begin
            next_q.mode_req = hwdata[3:0];
          end
        end
        OFS_MASK: next_q.irq_mask = hwdata[2:0];
        default: ;
      endcase
    end
    // Mode sequencer; a code written while settling waits for the count to end
    case (q.seq)
      ST_IDLE: begin
        if (q.mode_req != q.mode_act) begin
          if (q.mode_req == MODE_OFF || q.mode_req == MODE_STANDBY) begin
            next_q.seq = ST_DRAIN;
          end else begin
            next_q.mode_act = q.mode_req;
            next_q.ready    = 1'b0;
            next_q.cnt      = 16'(SETTLE_CYCLES);
            next_q.seq      = ST_SETTLE;
          end
        end
      end
      ST_DRAIN: begin
        // Hold old mode until the FIFO is empty
        if (i_fifo_empty) begin
          next_q.mode_act = q.mode_req;
          next_q.flush    = 1'b1;
          next_q.ready    = 1'b0;
          next_q.cnt      = 16'(SETTLE_CYCLES);
          next_q.seq      = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (q.cnt > 16'h1) begin
          next_q.cnt = q.cnt - 16'h1;
        end else begin
          next_q.cnt   = 16'h0;
          next_q.ready = 1'b1;
          next_q.seq   = ST_IDLE;
          ev[BIT_APPLIED] = 1'b1;
        end
      end
      default: next_q.seq = ST_IDLE;
    endcase
    ev[BIT_READY] = next_q.ready && !q.ready;
    ev[BIT_BROWN] = bo && !(q.irq_stat[BIT_BROWN]);
    // Read of the event register clears it; a new event wins
    if (q.dp_valid && !q.dp_write && q.dp_addr == OFS_IRQ) begin
      next_q.irq_stat = ev;
    end else begin
      next_q.irq_stat = q.irq_stat | ev;
    end
    // Deep sleep wipes only the interrupt mask; mode and event bits are kept
    if (q.mode_act == MODE_DEEP) begin
      next_q.irq_mask = RST_MASK;
    end
    // Address phase capture and read data
    next_q.dp_valid = take;
    next_q.dp_write = hwrite;
    next_q.dp_addr  = haddr[7:0];
    next_q.rdata    = 32'h0;
    if (take && !hwrite) begin
      // Ready reads low while a written mode still waits, so a poll that
      // follows a mode write's data phase can never pick up the old mode's ready
      case (haddr[7:0])
        OFS_MODE:   next_q.rdata = {28'h0, q.mode_req};
        OFS_STATUS: next_q.rdata = {29'h0, 1'b0, bo, q.ready && (q.mode_req == q.mode_act)};
        OFS_IRQ:    next_q.rdata = {29'h0, q.irq_stat};
        OFS_MASK:   next_q.rdata = {29'h0, q.irq_mask};
        default:    next_q.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.seq <= ST_IDLE;
      q.mode_req <= RST_MODE;
      q.mode_act <= RST_MODE;
      q.irq_mask <= RST_MASK;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata    = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Supplies decoded from mode in force
  assign o_core_supply_on = (q.mode_act != MODE_OFF) && (q.mode_act != MODE_DEEP);
  assign o_xtal_ref_on    = o_core_supply_on;
  assign o_rx_on          = (q.mode_act == MODE_RX) && q.ready;
  assign o_tx_on          = (q.mode_act == MODE_TX) && q.ready;
  assign o_fifo_access_ok = o_core_supply_on && (q.mode_act != MODE_STANDBY);
  assign o_fifo_flush     = q.flush;
  assign o_regs_lost      = (q.mode_act == MODE_DEEP);
  assign o_irq            = |(q.irq_stat & q.irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_off_no_supply: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.mode_act == MODE_OFF |-> !o_core_supply_on && !o_fifo_access_ok)
    else $error("supply on in power-down");
  a_drain_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.seq == ST_DRAIN && !i_fifo_empty |=> $stable(q.mode_act))
    else $error("mode changed before fifo empty");
  a_ready_settle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.seq == ST_SETTLE && q.cnt == 16'h1 |=> q.ready)
    else $error("ready not set after settle");
  a_auto_reg: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.seq == ST_IDLE && q.mode_req == MODE_TX && q.mode_act != MODE_TX
    |=> q.mode_act == MODE_TX ##[1:60] o_tx_on)
    else $error("transmit regulators not brought up");
  a_brown_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && !hwrite && haddr[7:0] == OFS_STATUS |=> hrdata[BIT_BROWN] == $past(bo))
    else $error("brownout flag misreported");
  a_deep_lost: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.mode_act == MODE_DEEP |-> (!o_core_supply_on && o_regs_lost) ##1 (q.irq_mask == RST_MASK))
    else $error("deep sleep kept state");
  // Leaving deep sleep may switch supplies on the very next cycle, so only the mask is looked at later
  a_ready_pending: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    take && !hwrite && haddr[7:0] == OFS_STATUS && q.mode_req != q.mode_act |=> !hrdata[BIT_READY])
    else $error("ready shown while mode change pending");
  a_legal_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mode_legal(q.mode_req) && mode_legal(q.mode_act))
    else $error("undefined mode code held");
  a_flush_empty: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_fifo_flush |-> $past(i_fifo_empty) && $past(q.seq) == ST_DRAIN)
    else $error("flush without drained fifo");
  c_tx: cover property (@(posedge i_clk) o_tx_on);
  c_rx: cover property (@(posedge i_clk) o_rx_on);
  c_drain: cover property (@(posedge i_clk) q.seq == ST_DRAIN ##1 q.seq == ST_DRAIN);
  c_irq: cover property (@(posedge i_clk) o_irq);

endmodule : radio_power_mode_sequencer

// *** pkg/radio_pwr_pkg.sv ***
package radio_pwr_pkg;
  // Power-mode codes
  localparam logic [3:0] MODE_OFF     = 4'h0;  // core_supply_off_state
  localparam logic [3:0] MODE_DEEP    = 4'h1;
  localparam logic [3:0] MODE_STANDBY = 4'h5;
  localparam logic [3:0] MODE_FIFO    = 4'h6;
  localparam logic [3:0] MODE_RX      = 4'h9;  // receive_active_state
  localparam logic [3:0] MODE_TX      = 4'hd;  // transmit_active_state
  // Register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00; // radio_power_state_select
  localparam logic [7:0] OFS_STATUS   = 8'h04; // supply_status_word
  localparam logic [7:0] OFS_IRQ      = 8'h08; // sticky events, clear on read
  localparam logic [7:0] OFS_MASK     = 8'h0c;
  // Status / event bit positions
  localparam int BIT_READY   = 0;  // regulator_ready_flag
  localparam int BIT_BROWN   = 1;  // brownout_flag
  localparam int BIT_APPLIED = 2;  // mode taken effect (event only)
  // Regulator settle time
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_NS        = 20;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  RST_MODE  = 4'h0;
  localparam logic [2:0]  RST_MASK  = 3'h0;
endpackage : radio_pwr_pkg

// *** test/fifo_drain_model.sv ***
`timescale 1ns/1ps
// FIFO behind the block: holds a burst for a while, then reads empty
module fifo_drain_model (
  input  wire logic i_clk,
  input  wire logic i_load,  // Pulse: a burst arrives
  output logic      o_empty  // High once nothing is queued
);
  logic [5:0] left = 6'h00;  // Words still queued
  // Drains one word a cycle; a slow drain lets the hold-off be seen
  always_ff @(posedge i_clk) begin
    if (i_load)
      left <= 6'h14;
    else if (left != 6'h00)
      left <= left - 6'h01;
  end
  assign o_empty = (left == 6'h00);
endmodule : fifo_drain_model

// *** test/radio_power_mode_sequencer_tb.sv ***
`timescale 1ns/1ps
module radio_power_mode_sequencer_tb;
  import radio_pwr_pkg::*;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, fifo_load = 1'b0, brown = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q;
  logic        hreadyout, fifo_empty, core_on, xtal_on, rx_on, tx_on, fifo_ok, flush, lost, irq;
  int          n_errors = 0, check_count = 0, flushes = 0;
  always #10 i_clk = ~i_clk;
  // Read data as it stood before the edge, so no race with the register
  always @(posedge i_clk) rd_q <= hrdata;
  always @(posedge i_clk) if (flush === 1'b1) flushes <= flushes + 1;
  radio_power_mode_sequencer uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .i_fifo_empty(fifo_empty), .i_brownout_pin(brown),
    .o_core_supply_on(core_on), .o_xtal_ref_on(xtal_on), .o_rx_on(rx_on), .o_tx_on(tx_on),
    .o_fifo_access_ok(fifo_ok), .o_fifo_flush(flush), .o_regs_lost(lost), .o_irq(irq));
  fifo_drain_model fifo (.i_clk(i_clk), .i_load(fifo_load), .o_empty(fifo_empty));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One single transfer; the address phase stands until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    #1 rd = rd_q;
  endtask : bus
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, ofs, d, v);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, ofs, 32'h0, v);
    chk(what, v, exp);
  endtask : rd
  // Software polls the ready flag; bounded so a dead regulator cannot hang us
  task automatic wait_ready();
    logic [31:0] v;
    v = 32'h0;
    repeat (100) if (v[BIT_READY] !== 1'b1) bus(1'b0, OFS_STATUS, 32'h0, v);
    chk("ready flag", {31'h0, v[BIT_READY]}, 32'h1);
  endtask : wait_ready
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("core at reset", {31'h0, core_on}, 32'h0);
    rd("mode at reset", OFS_MODE, {28'h0, RST_MODE});
    rd("mask at reset", OFS_MASK, {29'h0, RST_MASK});
  endtask : t_reset
  // Standby, active, off with a full FIFO at the start
  task automatic t_session(input logic [3:0] active);
    int f0;
    fifo_load <= 1'b1;
    @(posedge i_clk);
    fifo_load <= 1'b0;
    f0 = flushes;
    wr(OFS_MODE, {28'h0, MODE_STANDBY});
    // A few cycles in the FIFO still holds words, so standby must not be in force yet
    repeat (3) @(posedge i_clk);
    chk("held for drain", {31'h0, core_on}, 32'h0);
    wait_ready();
    chk("flush pulses", 32'(flushes - f0), 32'h1);
    chk("xtal on", {31'h0, xtal_on}, 32'h1);
    wr(OFS_MODE, {28'h0, active});
    // The active mode settles its regulators again before the path opens
    wait_ready();
    chk("tx path", {31'h0, tx_on}, {31'h0, active == MODE_TX});
    chk("rx path", {31'h0, rx_on}, {31'h0, active == MODE_RX});
    wr(OFS_MODE, {28'h0, MODE_OFF});
    // Let power-down settle, so the next scenario meets an idle sequencer
    wait_ready();
    chk("core off", {31'h0, core_on}, 32'h0);
    chk("fifo refused", {31'h0, fifo_ok}, 32'h0);
  endtask : t_session
  task automatic t_codes();
    wr(OFS_MODE, 32'h3);
    rd("undefined code", OFS_MODE, {28'h0, MODE_OFF});
    wr(OFS_MODE, {28'h0, MODE_FIFO});
    repeat (3) @(posedge i_clk);
    rd("fifo code", OFS_MODE, {28'h0, MODE_FIFO});
    chk("fifo access", {31'h0, fifo_ok}, 32'h1);
  endtask : t_codes
  // Brownout raises, masks through and clears by reading the events
  task automatic t_brown();
    logic [31:0] v;
    wr(OFS_MASK, 32'h2);
    brown <= 1'b1;
    repeat (4) @(posedge i_clk);
    bus(1'b0, OFS_STATUS, 32'h0, v);
    chk("brownout flag", {31'h0, v[BIT_BROWN]}, 32'h1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    brown <= 1'b0;
    repeat (4) @(posedge i_clk);
    bus(1'b0, OFS_IRQ, 32'h0, v);
    chk("brownout event", {31'h0, v[BIT_BROWN]}, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_brown
  task automatic t_deep();
    wr(OFS_MODE, {28'h0, MODE_DEEP});
    // Deep sleep waits for any settle in progress, then runs its own
    wait_ready();
    chk("regs lost", {31'h0, lost}, 32'h1);
    chk("supplies off", {31'h0, core_on}, 32'h0);
    rd("mask lost", OFS_MASK, 32'h0);
    rd("unmapped", 8'h10, 32'h0);
  endtask : t_deep
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Whole run is a few hundred cycles; this margin only catches a hang
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_session(MODE_TX);
    t_session(MODE_RX);
    t_codes();
    t_brown();
    t_deep();
    conclude();
  end
endmodule : radio_power_mode_sequencer_tb
